/* File: core/bsf_pkg.sv */
// package: operation codes, flag positions, register map, reset values and shared functions
package bsf_pkg;

   // operation codes in command-register order, starting at zero
   typedef enum logic [4:0] {
      op_no_operation,
      op_logical_shift_right,
      op_rotate_left_carry,
      op_rotate_right_carry,
      op_arithmetic_shift_right,
      op_nibble_swap,
      op_flag_set_generic,
      op_flag_clear_generic,
      op_bit_to_transfer_flag,
      op_transfer_flag_to_bit,
      op_carry_flag_set,
      op_carry_flag_clear,
      op_negative_flag_set,
      op_negative_flag_clear,
      op_zero_flag_set,
      op_zero_flag_clear,
      op_global_irq_on,
      op_global_irq_off,
      op_signed_flag_set,
      op_signed_flag_clear,
      op_overflow_flag_set,
      op_overflow_flag_clear,
      op_transfer_flag_set,
      op_transfer_flag_clear,
      op_half_carry_clear,
      op_sleep,
      op_watchdog_restart,
      op_debug_break
   } bsf_op_t;

   // status flag bit positions
   localparam logic [2:0] FLG_C = 3'h0;
   localparam logic [2:0] FLG_Z = 3'h1;
   localparam logic [2:0] FLG_N = 3'h2;
   localparam logic [2:0] FLG_V = 3'h3;
   localparam logic [2:0] FLG_S = 3'h4;
   localparam logic [2:0] FLG_H = 3'h5;
   localparam logic [2:0] FLG_T = 3'h6;
   localparam logic [2:0] FLG_I = 3'h7;

   // register byte addresses
   localparam logic [7:0] ADDR_WORK  = 8'h00;
   localparam logic [7:0] ADDR_FLAGS = 8'h04;
   localparam logic [7:0] ADDR_CMD   = 8'h08;
   localparam logic [7:0] ADDR_INFO  = 8'h0C;

   // command and info field positions
   localparam int unsigned CMD_OP_LSB  = 0;
   localparam int unsigned CMD_BIT_LSB = 8;
   localparam int unsigned INFO_CNT_LSB = 0;
   localparam int unsigned INFO_BAD_BIT = 8;
   localparam int unsigned INFO_DBG_BIT = 9;

   // reset values
   localparam logic [7:0] WORK_RST  = 8'h00;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] CNT_RST   = 8'h00;

   // one cycle per operation
   localparam int unsigned EXEC_CYCLES = 1;

   // flag update common to all four shifts: z, n from result, c from the shifted-out bit, v = n xor c
   function automatic logic [7:0] bsf_shift_flags(input logic [7:0] flags,
                                                  input logic [7:0] res,
                                                  input logic       carry);
      logic [7:0] f;
      f        = flags;
      f[FLG_C] = carry;
      f[FLG_Z] = (res == 8'h00);
      f[FLG_N] = res[7];
      f[FLG_V] = res[7] ^ carry;
      return f;
   endfunction : bsf_shift_flags

endpackage : bsf_pkg

/* File: core/bsf_shift_unit.sv */
// combinational shifter: logical, arithmetic and carry rotates plus nibble swap
module bsf_shift_unit
   import bsf_pkg::*;
(
   input  bsf_pkg::bsf_op_t op,
   input  logic [7:0]       val,
   input  logic [7:0]       flags,
   output logic             hit,
   output logic [7:0]       res,
   output logic [7:0]       flags_out
);
   logic c_old;

   assign c_old = flags[FLG_C];

   always_comb begin
      hit       = 1'b1;
      res       = val;
      flags_out = flags;
      case (op)
         op_logical_shift_right: begin
            res       = {1'b0, val[7:1]};
            flags_out = bsf_shift_flags(flags, res, val[0]);
         end
         op_rotate_left_carry: begin
            res       = {val[6:0], c_old};
            flags_out = bsf_shift_flags(flags, res, val[7]);
         end
         op_rotate_right_carry: begin
            res       = {c_old, val[7:1]};
            flags_out = bsf_shift_flags(flags, res, val[0]);
         end
         op_arithmetic_shift_right: begin
            res       = {val[7], val[7:1]};
            flags_out = bsf_shift_flags(flags, res, val[0]);
         end
         op_nibble_swap: begin
            res = {val[3:0], val[7:4]};
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end
endmodule : bsf_shift_unit

/* File: core/bsf_flag_unit.sv */
// combinational flag and single-bit transfer operations
module bsf_flag_unit
   import bsf_pkg::*;
(
   input  bsf_pkg::bsf_op_t op,
   input  logic [2:0]       bit_sel,
   input  logic [7:0]       val,
   input  logic [7:0]       flags,
   output logic [7:0]       res,
   output logic [7:0]       flags_out
);
   always_comb begin
      res       = val;
      flags_out = flags;
      case (op)
         op_flag_set_generic:     flags_out[bit_sel] = 1'b1;
         op_flag_clear_generic:   flags_out[bit_sel] = 1'b0;
         op_bit_to_transfer_flag: flags_out[FLG_T] = val[bit_sel];
         op_transfer_flag_to_bit: res[bit_sel] = flags[FLG_T];
         op_carry_flag_set:       flags_out[FLG_C] = 1'b1;
         op_carry_flag_clear:     flags_out[FLG_C] = 1'b0;
         op_negative_flag_set:    flags_out[FLG_N] = 1'b1;
         op_negative_flag_clear:  flags_out[FLG_N] = 1'b0;
         op_zero_flag_set:        flags_out[FLG_Z] = 1'b1;
         op_zero_flag_clear:      flags_out[FLG_Z] = 1'b0;
         op_global_irq_on:        flags_out[FLG_I] = 1'b1;
         op_global_irq_off:       flags_out[FLG_I] = 1'b0;
         op_signed_flag_set:      flags_out[FLG_S] = 1'b1;
         op_signed_flag_clear:    flags_out[FLG_S] = 1'b0;
         op_overflow_flag_set:    flags_out[FLG_V] = 1'b1;
         op_overflow_flag_clear:  flags_out[FLG_V] = 1'b0;
         op_transfer_flag_set:    flags_out[FLG_T] = 1'b1;
         op_transfer_flag_clear:  flags_out[FLG_T] = 1'b0;
         op_half_carry_clear:     flags_out[FLG_H] = 1'b0;
         default: begin
            res       = val;
            flags_out = flags;
         end
      endcase
   end
endmodule : bsf_flag_unit

/* File: core/bsf_top.sv */
// bit, shift and flag execution block with apb register access
//
// Chosen here: the APB slave port and the register addresses.

module bsf_top
   import bsf_pkg::*;
(
   input  logic        clk,
   input  logic        rst_n,
   input  logic        psel,
   input  logic        penable,
   input  logic        pwrite,
   input  logic [7:0]  paddr,
   input  logic [31:0] pwdata,
   input  logic [3:0]  pstrb,
   input  logic        debug_en,
   output logic        pready,
   output logic [31:0] prdata,
   output logic        pslverr,
   output logic [7:0]  work_value,
   output logic [7:0]  status_flags,
   output logic        sleep_req,
   output logic        wdog_restart,
   output logic        debug_break
);

   // apb handshake state
   logic        pready_q;
   logic [31:0] prdata_q;
   logic        pslverr_q;

   // architectural state
   logic [7:0]  work_q;
   logic [7:0]  work_d;
   logic [7:0]  flags_q;
   logic [7:0]  flags_d;

   // bookkeeping visible to software
   logic [4:0]  last_op_q;
   logic [2:0]  last_bit_q;
   logic [7:0]  exec_cnt_q;
   logic        bad_cmd_q;
   logic        dbg_seen_q;

   // event pulses
   logic        sleep_q;
   logic        wdog_q;
   logic        brk_q;

   // decoded access
   logic        acc_phase;
   logic        acc_commit;
   logic        wr_commit;
   logic        sel_work;
   logic        sel_flags;
   logic        sel_cmd;
   logic        sel_info;
   logic        addr_ok;
   logic        low_lane;
   logic        mid_lane;

   // sticky-bit events and clears
   logic        bad_set;
   logic        bad_clr;
   logic        dbg_clr;
   logic        brk_fire;

   // command decode
   logic [4:0]  cmd_code;
   logic [2:0]  cmd_bit;
   logic        cmd_valid;
   logic        cmd_fire;
   bsf_op_t     cmd_op;

   // unit results
   logic        sh_hit;
   logic [7:0]  sh_res;
   logic [7:0]  sh_flags;
   logic [7:0]  fl_res;
   logic [7:0]  fl_flags;
   logic [7:0]  exec_work;
   logic [7:0]  exec_flags;
   logic [31:0] rd_data;

   assign acc_phase  = psel & penable;
   // the transfer completes at the edge where the master sees pready high
   assign acc_commit = acc_phase & pready_q;
   assign wr_commit  = acc_commit & pwrite & ~pslverr_q;

   assign sel_work  = (paddr == ADDR_WORK);
   assign sel_flags = (paddr == ADDR_FLAGS);
   assign sel_cmd   = (paddr == ADDR_CMD);
   assign sel_info  = (paddr == ADDR_INFO);
   assign addr_ok   = sel_work | sel_flags | sel_cmd | sel_info;
   assign low_lane  = pstrb[0];
   assign mid_lane  = pstrb[1];

   assign cmd_code  = pwdata[CMD_OP_LSB +: 5];
   assign cmd_bit   = pwdata[CMD_BIT_LSB +: 3];
   // codes past the last operation are refused and flagged
   assign cmd_valid = (cmd_code <= 5'(op_debug_break));
   assign cmd_op    = bsf_op_t'(cmd_code);
   // a command needs both lanes so that code and bit select arrive together
   assign cmd_fire  = wr_commit & sel_cmd & low_lane & mid_lane & cmd_valid;

   // a refused code still completes the transfer cleanly; only the sticky bit records it
   assign bad_set  = wr_commit & sel_cmd & ~cmd_valid;
   assign bad_clr  = wr_commit & sel_info & mid_lane & pwdata[INFO_BAD_BIT];
   assign dbg_clr  = wr_commit & sel_info & mid_lane & pwdata[INFO_DBG_BIT];
   // break only reaches the debug system when enabled; otherwise it retires as a no-op
   assign brk_fire = cmd_fire & (cmd_op == op_debug_break) & debug_en;

   bsf_shift_unit u_shift (
      .op        (cmd_op),
      .val       (work_q),
      .flags     (flags_q),
      .hit       (sh_hit),
      .res       (sh_res),
      .flags_out (sh_flags)
   );

   bsf_flag_unit u_flag (
      .op        (cmd_op),
      .bit_sel   (cmd_bit),
      .val       (work_q),
      .flags     (flags_q),
      .res       (fl_res),
      .flags_out (fl_flags)
   );

   // shifts and bit moves are disjoint; the flag unit passes values through for shifts
   assign exec_work  = sh_hit ? sh_res : fl_res;
   assign exec_flags = sh_hit ? sh_flags : fl_flags;

   // next working register: command result wins the cycle, else direct software write
   always_comb begin
      work_d = work_q;
      if (cmd_fire) begin
         case (cmd_op)
            op_no_operation: work_d = work_q;
            op_sleep:        work_d = work_q;
            op_watchdog_restart: work_d = work_q;
            op_debug_break:  work_d = work_q;
            default:         work_d = exec_work;
         endcase
      end else if (wr_commit & sel_work & low_lane) begin
         work_d = pwdata[7:0];
      end
   end

   // next flags: control operations leave every flag as it was
   always_comb begin
      flags_d = flags_q;
      if (cmd_fire) begin
         case (cmd_op)
            op_no_operation: flags_d = flags_q;
            op_sleep:        flags_d = flags_q;
            op_watchdog_restart: flags_d = flags_q;
            op_debug_break:  flags_d = flags_q;
            default:         flags_d = exec_flags;
         endcase
      end else if (wr_commit & sel_flags & low_lane) begin
         flags_d = pwdata[7:0];
      end
   end

   // every operation retires at the commit edge, EXEC_CYCLES after the command lands
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         work_q <= WORK_RST;
      end else begin
         work_q <= work_d;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flags_q <= FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // sleep request pulse for the power manager
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_q <= 1'b0;
      end else begin
         sleep_q <= cmd_fire & (cmd_op == op_sleep);
      end
   end

   // watchdog restart pulse; the timer owns what restart means
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wdog_q <= 1'b0;
      end else begin
         wdog_q <= cmd_fire & (cmd_op == op_watchdog_restart);
      end
   end

   // debug break pulse, one cycle per enabled break
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         brk_q <= 1'b0;
      end else begin
         brk_q <= brk_fire;
      end
   end

   // last command and retired-operation counter; counter wraps at 255
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         last_op_q  <= 5'h00;
         last_bit_q <= 3'h0;
         exec_cnt_q <= CNT_RST;
      end else if (cmd_fire) begin
         last_op_q  <= cmd_code;
         last_bit_q <= cmd_bit;
         exec_cnt_q <= exec_cnt_q + 8'h01;
      end
   end

   // sticky error and break-seen bits: write one to clear, a new event wins over the clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bad_cmd_q <= 1'b0;
      end else if (bad_set) begin
         bad_cmd_q <= 1'b1;
      end else if (bad_clr) begin
         bad_cmd_q <= 1'b0;
      end
   end

   // break-seen bit follows the same rule: the event beats a clear in one cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dbg_seen_q <= 1'b0;
      end else if (brk_fire) begin
         dbg_seen_q <= 1'b1;
      end else if (dbg_clr) begin
         dbg_seen_q <= 1'b0;
      end
   end

   // read mux; command register reads back the last accepted command
   always_comb begin
      rd_data = 32'h0000_0000;
      case (1'b1)
         sel_work:  rd_data[7:0] = work_q;
         sel_flags: rd_data[7:0] = flags_q;
         sel_cmd: begin
            rd_data[CMD_OP_LSB +: 5]  = last_op_q;
            rd_data[CMD_BIT_LSB +: 3] = last_bit_q;
         end
         sel_info: begin
            rd_data[INFO_CNT_LSB +: 8] = exec_cnt_q;
            rd_data[INFO_BAD_BIT]      = bad_cmd_q;
            rd_data[INFO_DBG_BIT]      = dbg_seen_q;
         end
         default: rd_data = 32'h0000_0000;
      endcase
   end

   // one wait state: pready rises in the second access cycle, data and error with it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (acc_commit) begin
         pready_q  <= 1'b0;
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (acc_phase) begin
         pready_q  <= 1'b1;
         prdata_q  <= pwrite ? 32'h0000_0000 : rd_data;
         // only an unmapped address is refused; info writes are accepted for their clear bits
         pslverr_q <= ~addr_ok;
      end
   end

   assign pready       = pready_q;
   assign prdata       = prdata_q;
   assign pslverr      = pslverr_q;
   assign work_value   = work_q;
   assign status_flags = flags_q;
   assign sleep_req    = sleep_q;
   assign wdog_restart = wdog_q;
   assign debug_break  = brk_q;

endmodule : bsf_top

/* File: test/bsf_top_monitor.sv */
// checker: port-level timing and flag relations of the bit, shift and flag block
module bsf_top_monitor
   import bsf_pkg::*;
(
   input logic        clk,
   input logic        rst_n,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [7:0]  paddr,
   input logic [31:0] pwdata,
   input logic [3:0]  pstrb,
   input logic        debug_en,
   input logic        pready,
   input logic [31:0] prdata,
   input logic        pslverr,
   input logic [7:0]  work_value,
   input logic [7:0]  status_flags,
   input logic        sleep_req,
   input logic        wdog_restart,
   input logic        debug_break
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic       cmd_go;
   logic [4:0] cmd_op;
   // a command only counts when both low strobe lanes are present
   assign cmd_go = psel && penable && pready && pwrite && paddr == ADDR_CMD && pstrb[1:0] == 2'h3;
   assign cmd_op = pwdata[4:0];
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("prdata not zero outside answer");
   chk_work_cause: assert property (!$stable(work_value) |-> $past(pwrite && pready))
      else $error("work changed without a write");
   chk_flags_cause: assert property (!$stable(status_flags) |-> $past(pwrite && pready))
      else $error("flags changed without a write");
   chk_quiet_ops: assert property (
      cmd_go && cmd_op inside {5'h00, 5'h05, 5'h19, 5'h1A, 5'h1B}
      |=> $stable(status_flags))
      else $error("flags moved on a quiet command");
   chk_work_kept: assert property (
      cmd_go && (cmd_op inside {5'h06, 5'h07, 5'h08} || cmd_op > 5'h09)
      |=> $stable(work_value))
      else $error("work moved on a flag command");
   chk_shift_flags: assert property (
      cmd_go && cmd_op inside {[5'h01:5'h04]} |=>
      status_flags[3:1] == {work_value[7] ^ status_flags[0], work_value[7], work_value == 8'h00}
      && status_flags[7:4] == $past(status_flags[7:4]))
      else $error("shift flags inconsistent");
   chk_sleep_cause: assert property (sleep_req |-> $past(cmd_go && cmd_op == 5'h19))
      else $error("sleep request without command");
   chk_sleep_pulse: assert property (cmd_go && cmd_op == 5'h19 |=> sleep_req ##1 !sleep_req)
      else $error("sleep request not a single pulse");
   chk_wdog_cause: assert property (wdog_restart |-> $past(cmd_go && cmd_op == 5'h1A))
      else $error("watchdog restart without command");
   chk_break_gate: assert property (debug_break |-> $past(cmd_go && cmd_op == 5'h1B && debug_en))
      else $error("break pulse without enabled debug");
endmodule : bsf_top_monitor

bind bsf_top bsf_top_monitor u_mon (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .debug_en(debug_en),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .work_value(work_value),
   .status_flags(status_flags), .sleep_req(sleep_req), .wdog_restart(wdog_restart),
   .debug_break(debug_break));

/* File: test/bsf_top_tb.sv */
// testbench: apb driven command sweep with a reference model and queued read checks
module bsf_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import bsf_pkg::*;
   typedef struct {logic [31:0] d; logic [31:0] m; logic e;} bsf_exp_t;
   logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, debug_en = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic        pready, pslverr, sleep_req, wdog_restart, debug_break;
   logic [31:0] prdata;
   logic [7:0]  work_value, status_flags, w, f;
   logic [31:0] seed = 32'h0000D180, r;
   logic [4:0]  op;
   logic [2:0]  b;
   int          bad_count = 0, comparisons = 0, n_slp = 0, n_wdr = 0, n_brk = 0;
   bsf_exp_t    q[$];
   bsf_exp_t    e;

   bsf_top dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .debug_en(debug_en), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .work_value(work_value), .status_flags(status_flags),
      .sleep_req(sleep_req), .wdog_restart(wdog_restart), .debug_break(debug_break));

   initial begin
      forever #2.5 clk = ~clk;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic final_report();
      if (bad_count == 0 && comparisons > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : final_report

   // one transfer; the next call's setup releases penable, so no signal is driven twice
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [31:0] ed, input logic [31:0] m,
                      input logic ee);
      q.push_back('{ed, m, ee});
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      apb(1'b1, a, d, s, 32'h0, 32'h0, 1'b0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [31:0] m);
      apb(1'b0, a, 32'h0, 4'h0, ed, m, 1'b0);
   endtask : rd

   // reference model of one command on the expected work and flags
   task automatic exec(input logic [4:0] o, input logic [2:0] bs);
      int         m[7] = '{0, 2, 1, 7, 4, 3, 6};
      logic [7:0] res;
      logic       c;
      res = w;
      c = f[0];
      case (o)
         5'h01: {res, c} = {1'b0, w};
         5'h02: {c, res} = {w, f[0]};
         5'h03: {res, c} = {f[0], w};
         5'h04: {res, c} = {w[7], w};
         5'h05: res = {w[3:0], w[7:4]};
         5'h06: f[bs] = 1'b1;
         5'h07: f[bs] = 1'b0;
         5'h08: f[6] = w[bs];
         5'h09: res[bs] = f[6];
         5'h18: f[5] = 1'b0;
         default: if (o >= 5'h0A && o <= 5'h17) f[m[(o - 5'h0A) / 2]] = ~o[0];
      endcase
      if (o >= 5'h01 && o <= 5'h04) f[3:0] = {res[7] ^ c, res[7], res == 8'h00, c};
      w = res;
   endtask : exec

   // result watcher: every finished transfer takes the oldest note
   always @(posedge clk) begin
      if (psel && penable && pready === 1'b1) begin
         e = q.pop_front();
         check("prdata", prdata & e.m, e.d & e.m);
         check("pslverr", 32'(pslverr), 32'(e.e));
      end
      if (sleep_req === 1'b1) n_slp++;
      if (wdog_restart === 1'b1) n_wdr++;
      if (debug_break === 1'b1) n_brk++;
   end

   initial begin
      repeat (5000) @(posedge clk);
      bad_count++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(ADDR_WORK, 32'h0, '1);
      rd(ADDR_FLAGS, 32'h0, '1);
      rd(ADDR_INFO, 32'h0, '1);
      debug_en <= 1'b1;
      // every code three times on fresh random work and flags
      for (int i = 0; i < 84; i++) begin
         op = 5'(i % 28);
         r = xs();
         w = r[7:0];
         f = r[15:8];
         b = r[18:16];
         wr(ADDR_WORK, {24'h0, w}, 4'hF);
         wr(ADDR_FLAGS, {24'h0, f}, 4'hF);
         wr(ADDR_CMD, {21'h0, b, 3'h0, op}, 4'h3);
         exec(op, b);
         rd(ADDR_WORK, {24'h0, w}, '1);
         rd(ADDR_FLAGS, {24'h0, f}, '1);
         rd(ADDR_CMD, {21'h0, b, 3'h0, op}, '1);
      end
      rd(ADDR_INFO, 32'h254, '1);
      // sticky bits clear on write of ones, counter stays
      wr(ADDR_INFO, 32'h3FF, 4'hF);
      rd(ADDR_INFO, 32'h54, '1);
      // missing strobe lane: command ignored
      wr(ADDR_CMD, 32'h1, 4'h1);
      rd(ADDR_WORK, {24'h0, w}, '1);
      wr(ADDR_CMD, 32'h1C, 4'h3);
      rd(ADDR_INFO, 32'h100, 32'h100);
      debug_en <= 1'b0;
      wr(ADDR_CMD, 32'h1B, 4'h3);
      rd(ADDR_FLAGS, {24'h0, f}, '1);
      apb(1'b0, 8'h10, 32'h0, 4'h0, 32'h0, '1, 1'b1);
      apb(1'b1, 8'h14, 32'h5A, 4'hF, 32'h0, 32'h0, 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      repeat (3) @(posedge clk);
      check("sleep pulses", n_slp, 3);
      check("restart pulses", n_wdr, 3);
      check("break pulses", n_brk, 3);
      final_report();
   end
endmodule : bsf_top_tb
